// *** rtl/ssdf_pkg.sv ***
// Constants, track layout lengths and state types of the soft-sector formatter.
// Assumes one byte clock domain; every byte time is marked by a tick from the channel.
package ssdf_pkg;

	// ******************************************************************
	// Track bytes
	// ******************************************************************
	localparam logic [7:0]  FILL_BYTE         = 8'h4e;
	localparam logic [7:0]  ZERO_BYTE         = 8'h00;
	localparam logic [7:0]  MARK_BYTE         = 8'ha1;
	localparam logic [7:0]  ID_SYNC           = 8'hfe;
	localparam logic [7:0]  DATA_SYNC         = 8'hf8;

	// ******************************************************************
	// Field lengths in bytes
	// ******************************************************************
	localparam logic [9:0]  LEN_PRE_GAP       = 10'h010;
	localparam logic [9:0]  LEN_PRE_ZERO      = 10'h00e;
	localparam logic [9:0]  LEN_ONE           = 10'h001;
	localparam logic [9:0]  LEN_HDR_ID        = 10'h004;
	localparam logic [9:0]  LEN_CRC           = 10'h002;
	localparam logic [9:0]  LEN_HDR_GAP       = 10'h00a;
	localparam logic [9:0]  LEN_DATA_ZERO     = 10'h00c;
	localparam logic [9:0]  LEN_DATA          = 10'h200;
	localparam logic [9:0]  LEN_TAIL          = 10'h003;
	localparam logic [9:0]  LEN_DATA_GAP      = 10'h00f;
	localparam logic [4:0]  SECTORS_PER_TRACK = 5'h11;

	// ******************************************************************
	// Header byte positions while searching
	// ******************************************************************
	localparam logic [9:0]  HB_SYNC           = 10'h000;
	localparam logic [9:0]  HB_CYL            = 10'h001;
	localparam logic [9:0]  HB_HEAD           = 10'h002;
	localparam logic [9:0]  HB_SECT           = 10'h003;
	localparam logic [9:0]  HB_LAST           = 10'h005;
	localparam int          HEAD_MSB          = 7;
	localparam int          HEAD_LSB          = 4;
	localparam int          BAD_BIT           = 3;
	localparam int          CYLHI_MSB         = 2;

	// ******************************************************************
	// Data field positions while reading
	// ******************************************************************
	localparam logic [9:0]  RD_SYNC           = 10'h000;
	localparam logic [9:0]  RD_FIRST          = 10'h001;
	localparam logic [9:0]  RD_LAST_DATA      = 10'h200;
	localparam logic [9:0]  RD_LAST           = 10'h202;
	localparam logic [1:0]  MISS_INDEX        = 2'h2;

	// ******************************************************************
	// Checksum and commands
	// ******************************************************************
	localparam logic [15:0] CRC_INIT          = 16'hffff;
	localparam logic [15:0] CRC_POLY          = 16'h1021;
	localparam logic [1:0]  OP_READ           = 2'h0;
	localparam logic [1:0]  OP_WRITE          = 2'h1;
	localparam logic [1:0]  OP_FORMAT         = 2'h2;

	typedef enum logic [4:0] {
		S_IDLE, S_WAIT_RDY, S_WAIT_IDX, S_PRE_GAP, S_PRE_ZERO,
		S_HMARK, S_HID, S_HCRC, S_HGAP,
		S_DZERO, S_DMARK, S_DF8, S_DATA, S_DCRC, S_DTAIL, S_DGAP, S_FILL,
		S_SEEK_MARK, S_SEEK_HDR, S_RD_MARK, S_RD_DATA, S_DONE
	} ssdf_state_t;

endpackage

// *** rtl/ssdf_pair_buffer.sv ***
// Small FIFO that decouples disk read bytes from the host drain side.
// Assumes push and pop handshakes sampled on clk; data leaves from storage flops.
`timescale 1ns/1ps
module ssdf_pair_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             push_valid,
	output logic                  push_ready,
	input  wire logic [WIDTH-1:0] push_data,
	output logic                  pop_valid,
	input  wire logic             pop_ready,
	output logic [WIDTH-1:0]      pop_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	wire              do_push = push_valid && push_ready;
	wire              do_pop  = pop_valid && pop_ready;

	assign push_ready = (count != FULL_COUNT);
	assign pop_valid  = (count != '0);
	assign pop_data   = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PW'(1);
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PW'(1);
			end
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end

endmodule // ssdf_pair_buffer

// *** rtl/ssdf_formatter.sv ***
// Sector framer and command sequencer for a soft-sectored hard disk channel.
// Assumes the channel gives one byte_tick per byte time and serialises wr_data,
// and that the read channel flags each detected address mark with rd_mark.
`timescale 1ns/1ps

module ssdf_formatter (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [1:0]  cmd_op,
	input  wire logic [3:0]  tgt_head,
	input  wire logic [7:0]  tgt_sector,
	input  wire logic [10:0] tgt_cyl,
	input  wire logic [1:0]  sel_req,
	input  wire logic        drive_ready,
	input  wire logic        power_fail,
	output logic [1:0]       drive_sel,
	input  wire logic        index_pulse,
	input  wire logic        byte_tick,
	output logic [7:0]       wr_data,
	output logic             wr_mark,
	output logic             wr_gate,
	input  wire logic        rd_valid,
	input  wire logic [7:0]  rd_byte,
	input  wire logic        rd_mark,
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_data,
	output logic             in_ready,
	output logic             out_valid,
	output logic [7:0]       out_data,
	input  wire logic        out_ready,
	output logic             busy,
	output logic             op_done,
	output logic             record_missing_flag,
	output logic             crc_error,
	output logic             bad_sector,
	output logic             overrun
);
	// ******************************************************************
	// Helpers
	// ******************************************************************
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ ssdf_pkg::CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [9:0] seg_len(input ssdf_pkg::ssdf_state_t s);
		case (s)
			ssdf_pkg::S_PRE_GAP:  seg_len = ssdf_pkg::LEN_PRE_GAP;
			ssdf_pkg::S_PRE_ZERO: seg_len = ssdf_pkg::LEN_PRE_ZERO;
			ssdf_pkg::S_HID:      seg_len = ssdf_pkg::LEN_HDR_ID;
			ssdf_pkg::S_HCRC:     seg_len = ssdf_pkg::LEN_CRC;
			ssdf_pkg::S_HGAP:     seg_len = ssdf_pkg::LEN_HDR_GAP;
			ssdf_pkg::S_DZERO:    seg_len = ssdf_pkg::LEN_DATA_ZERO;
			ssdf_pkg::S_DATA:     seg_len = ssdf_pkg::LEN_DATA;
			ssdf_pkg::S_DCRC:     seg_len = ssdf_pkg::LEN_CRC;
			ssdf_pkg::S_DTAIL:    seg_len = ssdf_pkg::LEN_TAIL;
			ssdf_pkg::S_DGAP:     seg_len = ssdf_pkg::LEN_DATA_GAP;
			default:              seg_len = ssdf_pkg::LEN_ONE;
		endcase
	endfunction

	function automatic logic is_emit(input ssdf_pkg::ssdf_state_t s);
		is_emit = (s >= ssdf_pkg::S_PRE_GAP) && (s <= ssdf_pkg::S_FILL);
	endfunction

	// ******************************************************************
	// State
	// ******************************************************************
	ssdf_pkg::ssdf_state_t state;
	ssdf_pkg::ssdf_state_t next_state;
	logic [1:0]  op;
	logic [9:0]  cnt;
	logic [4:0]  sec_cnt;
	logic [15:0] crc;
	logic [1:0]  idx_seen;
	logic        idx_q;
	logic        hdr_hit;
	logic        hdr_bad;

	wire         idx_rise   = index_pulse && !idx_q;
	wire         drive_ok   = drive_ready && (drive_sel != 2'h0);
	wire         emitting   = is_emit(state);
	wire         seg_end    = (cnt == seg_len(state) - ssdf_pkg::LEN_ONE);
	wire         op_fmt     = (op == ssdf_pkg::OP_FORMAT);
	wire         op_wr      = (op == ssdf_pkg::OP_WRITE);
	wire         searching  = (state == ssdf_pkg::S_SEEK_MARK) || (state == ssdf_pkg::S_SEEK_HDR);
	wire [15:0]  crc_rd     = crc_byte(crc, rd_byte);
	wire [15:0]  crc_mark   = crc_byte(ssdf_pkg::CRC_INIT, ssdf_pkg::MARK_BYTE);
	wire         hdr_final  = (state == ssdf_pkg::S_SEEK_HDR) && rd_valid
	                          && (cnt == ssdf_pkg::HB_LAST);
	wire         rd_final   = (state == ssdf_pkg::S_RD_DATA) && rd_valid
	                          && (cnt == ssdf_pkg::RD_LAST);
	wire         rd_badsync = (state == ssdf_pkg::S_RD_DATA) && rd_valid
	                          && (cnt == ssdf_pkg::RD_SYNC) && (rd_byte != ssdf_pkg::DATA_SYNC);
	wire         push_valid = (state == ssdf_pkg::S_RD_DATA) && rd_valid
	                          && (cnt >= ssdf_pkg::RD_FIRST) && (cnt <= ssdf_pkg::RD_LAST_DATA);
	wire         push_ready;
	wire         take_cmd   = cmd_valid && cmd_ready;

	// ******************************************************************
	// Byte to emit
	// ******************************************************************
	wire         cur_mark   = (state == ssdf_pkg::S_HMARK) || (state == ssdf_pkg::S_DMARK);
	wire         host_byte  = (state == ssdf_pkg::S_HID) || (state == ssdf_pkg::S_DATA && op_wr);
	wire [7:0]   host_val   = in_valid ? in_data : ssdf_pkg::ZERO_BYTE;
	wire [7:0]   crc_val    = (cnt == '0) ? crc[15:8] : crc[7:0];
	wire         crc_seg    = (state == ssdf_pkg::S_HCRC) || (state == ssdf_pkg::S_DCRC);
	wire         fill_seg   = (state == ssdf_pkg::S_PRE_GAP) || (state == ssdf_pkg::S_DGAP)
	                          || (state == ssdf_pkg::S_FILL) || (state == ssdf_pkg::S_DATA);
	wire [7:0]   cur_byte   = cur_mark  ? ssdf_pkg::MARK_BYTE :
	                          host_byte ? host_val :
	                          (state == ssdf_pkg::S_DF8) ? ssdf_pkg::DATA_SYNC :
	                          crc_seg   ? crc_val :
	                          fill_seg  ? ssdf_pkg::FILL_BYTE :
	                          ssdf_pkg::ZERO_BYTE;
	wire         crc_feed   = cur_mark || host_byte || (state == ssdf_pkg::S_DF8)
	                          || (state == ssdf_pkg::S_DATA);

	assign cmd_ready = (state == ssdf_pkg::S_IDLE);
	assign in_ready  = byte_tick && host_byte;
	assign busy      = (state != ssdf_pkg::S_IDLE);

	// ******************************************************************
	// Sequencer
	// ******************************************************************
	always_comb begin
		next_state = state;
		case (state)
			ssdf_pkg::S_IDLE:      if (take_cmd) next_state = ssdf_pkg::S_WAIT_RDY;
			ssdf_pkg::S_WAIT_RDY: begin
				if (drive_ok) begin
					next_state = op_fmt ? ssdf_pkg::S_WAIT_IDX :
					             (op == 2'h3) ? ssdf_pkg::S_DONE : ssdf_pkg::S_SEEK_MARK;
				end
			end
			ssdf_pkg::S_WAIT_IDX:  if (idx_rise) next_state = ssdf_pkg::S_PRE_GAP;
			ssdf_pkg::S_SEEK_MARK: begin
				if (idx_seen == ssdf_pkg::MISS_INDEX) next_state = ssdf_pkg::S_DONE;
				else if (rd_valid && rd_mark) next_state = ssdf_pkg::S_SEEK_HDR;
			end
			ssdf_pkg::S_SEEK_HDR: begin
				if (hdr_final) begin
					if (!hdr_hit) next_state = ssdf_pkg::S_SEEK_MARK;
					else if (crc_rd != '0 || hdr_bad) next_state = ssdf_pkg::S_DONE;
					else next_state = op_wr ? ssdf_pkg::S_DZERO : ssdf_pkg::S_RD_MARK;
				end
			end
			ssdf_pkg::S_RD_MARK:   if (rd_valid && rd_mark) next_state = ssdf_pkg::S_RD_DATA;
			ssdf_pkg::S_RD_DATA:   if (rd_final || rd_badsync) next_state = ssdf_pkg::S_DONE;
			ssdf_pkg::S_FILL:      if (idx_rise) next_state = ssdf_pkg::S_DONE;
			ssdf_pkg::S_DONE:      next_state = ssdf_pkg::S_IDLE;
			default: begin
				if (emitting && byte_tick && seg_end) begin
					if (state == ssdf_pkg::S_DGAP) begin
						next_state = !op_fmt ? ssdf_pkg::S_DONE :
						             (sec_cnt == ssdf_pkg::SECTORS_PER_TRACK - 5'h1) ?
						             ssdf_pkg::S_FILL : ssdf_pkg::S_HMARK;
					end else if (state == ssdf_pkg::S_HGAP) begin
						next_state = ssdf_pkg::S_DZERO;
					end else begin
						next_state = ssdf_pkg::ssdf_state_t'(state + 5'h1);
					end
				end
			end
		endcase
		if (power_fail && state != ssdf_pkg::S_IDLE) next_state = ssdf_pkg::S_IDLE;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ssdf_pkg::S_IDLE;
			op    <= ssdf_pkg::OP_READ;
			idx_q <= 1'b0;
		end else begin
			state <= next_state;
			idx_q <= index_pulse;
			if (take_cmd) op <= cmd_op;
		end
	end

	// Counter restarts on every state change so each segment counts from zero
	always_ff @(posedge clk) begin
		if (sys_rst || state != next_state) begin
			cnt <= '0;
		end else if ((emitting && byte_tick) || (rd_valid && !emitting)) begin
			cnt <= cnt + 10'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || state == ssdf_pkg::S_WAIT_IDX) begin
			sec_cnt <= '0;
		end else if (state == ssdf_pkg::S_DGAP && byte_tick && seg_end) begin
			sec_cnt <= sec_cnt + 5'h01;
		end
	end

	// Two index pulses without a matching header means the sector is absent
	always_ff @(posedge clk) begin
		if (sys_rst || !searching) begin
			idx_seen <= '0;
		end else if (idx_rise && idx_seen != ssdf_pkg::MISS_INDEX) begin
			idx_seen <= idx_seen + 2'h1;
		end
	end

	// ******************************************************************
	// Checksum and header compare
	// ******************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			crc <= ssdf_pkg::CRC_INIT;
		end else if (emitting && byte_tick && cur_mark) begin
			crc <= crc_mark;
		end else if (emitting && byte_tick && crc_feed) begin
			crc <= crc_byte(crc, cur_byte);
		end else if (!emitting && rd_valid && rd_mark) begin
			crc <= crc_mark;
		end else if (!emitting && rd_valid) begin
			crc <= crc_rd;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hdr_hit <= 1'b0;
			hdr_bad <= 1'b0;
		end else if (state == ssdf_pkg::S_SEEK_HDR && rd_valid) begin
			case (cnt)
				ssdf_pkg::HB_SYNC: hdr_hit <= (rd_byte == ssdf_pkg::ID_SYNC);
				ssdf_pkg::HB_CYL:  hdr_hit <= hdr_hit && (rd_byte == tgt_cyl[7:0]);
				ssdf_pkg::HB_HEAD: begin
					hdr_hit <= hdr_hit
					           && (rd_byte[ssdf_pkg::HEAD_MSB:ssdf_pkg::HEAD_LSB] == tgt_head)
					           && (rd_byte[ssdf_pkg::CYLHI_MSB:0] == tgt_cyl[10:8]);
					hdr_bad <= rd_byte[ssdf_pkg::BAD_BIT];
				end
				ssdf_pkg::HB_SECT: hdr_hit <= hdr_hit && (rd_byte == tgt_sector);
				default:           hdr_hit <= hdr_hit;
			endcase
		end
	end

	// ******************************************************************
	// Status and interrupt
	// ******************************************************************
	// Status clears on a new command, so a stale error never blocks the next one
	always_ff @(posedge clk) begin
		if (sys_rst || take_cmd) begin
			record_missing_flag <= 1'b0;
			crc_error           <= 1'b0;
			bad_sector          <= 1'b0;
			overrun             <= 1'b0;
		end else begin
			if ((state == ssdf_pkg::S_SEEK_MARK && idx_seen == ssdf_pkg::MISS_INDEX)
			    || rd_badsync) record_missing_flag <= 1'b1;
			if ((hdr_final && hdr_hit && crc_rd != '0) || (rd_final && crc_rd != '0))
				crc_error <= 1'b1;
			if (hdr_final && hdr_hit && hdr_bad) bad_sector <= 1'b1;
			if (push_valid && !push_ready) overrun <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			op_done <= 1'b0;
		end else begin
			op_done <= (state == ssdf_pkg::S_DONE);
		end
	end

	// ******************************************************************
	// Drive outputs
	// ******************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			drive_sel <= 2'h0;
			wr_data   <= ssdf_pkg::ZERO_BYTE;
			wr_mark   <= 1'b0;
			wr_gate   <= 1'b0;
		end else begin
			drive_sel <= power_fail ? 2'h0 : sel_req;
			if (power_fail) begin
				wr_gate <= 1'b0;
				wr_mark <= 1'b0;
			end else if (byte_tick) begin
				wr_data <= cur_byte;
				wr_mark <= emitting && cur_mark;
				wr_gate <= emitting;
			end
		end
	end

	// ******************************************************************
	// Read data buffer
	// ******************************************************************
	// The disk cannot be stalled; a full buffer is reported as overrun
	ssdf_pair_buffer #(
		.WIDTH (8),
		.DEPTH (2)
	) u_buf (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.push_valid (push_valid),
		.push_ready (push_ready),
		.push_data  (rd_byte),
		.pop_valid  (out_valid),
		.pop_ready  (out_ready),
		.pop_data   (out_data)
	);

	// ******************************************************************
	// Checks
	// ******************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	power_off_sel_a: assert property (power_fail |=> drive_sel == 2'h0 && !wr_gate)
		else $error("drive still selected during power fail");
	seek_no_write_a: assert property (searching |=> !wr_gate)
		else $error("write gate raised before sector matched");
	mark_clock_a: assert property (wr_mark |-> wr_data == ssdf_pkg::MARK_BYTE && wr_gate)
		else $error("missing clock on a non mark byte");
	done_pulse_a: assert property (state == ssdf_pkg::S_DONE |=> op_done ##1 !op_done)
		else $error("completion pulse wrong");
	irq_cause_a: assert property (op_done |-> $past(state) == ssdf_pkg::S_DONE)
		else $error("interrupt without completed operation");
	pending_cmd_a: assert property (state == ssdf_pkg::S_WAIT_RDY && !drive_ok && !power_fail
		|=> state == ssdf_pkg::S_WAIT_RDY)
		else $error("command ran before drive ready");
	fmt_start_a: assert property (state == ssdf_pkg::S_WAIT_IDX && idx_rise && !power_fail
		|=> state == ssdf_pkg::S_PRE_GAP)
		else $error("format did not start at index");
	data_sync_a: assert property (byte_tick && state == ssdf_pkg::S_DF8 && !power_fail
		|=> wr_data == ssdf_pkg::DATA_SYNC && $past(wr_mark))
		else $error("data sync not after mark");
	fmt_fill_a: assert property (byte_tick && state == ssdf_pkg::S_DATA && op_fmt && !power_fail
		|=> wr_data == ssdf_pkg::FILL_BYTE)
		else $error("format data byte not fill");
	host_data_a: assert property (byte_tick && state == ssdf_pkg::S_DATA && op_wr && in_valid
		&& !power_fail |=> wr_data == $past(in_data))
		else $error("write data not from host");
	hdr_gap_a: assert property (byte_tick && state == ssdf_pkg::S_HGAP && !power_fail
		|=> wr_data == ssdf_pkg::ZERO_BYTE && !wr_mark)
		else $error("header gap not zero");
	sector_count_a: assert property (state == ssdf_pkg::S_FILL
		|-> sec_cnt == ssdf_pkg::SECTORS_PER_TRACK)
		else $error("track filled before all sectors");
	tail_fill_a: assert property (byte_tick && state == ssdf_pkg::S_FILL && !power_fail
		|=> wr_data == ssdf_pkg::FILL_BYTE && wr_gate)
		else $error("tail fill missing");

	fmt_done_c: cover property (state == ssdf_pkg::S_FILL ##1 state == ssdf_pkg::S_DONE);
	write_done_c: cover property (state == ssdf_pkg::S_DGAP && op_wr ##1 state == ssdf_pkg::S_DONE);
	read_done_c: cover property (rd_final && crc_rd == '0);
	missing_c: cover property ($rose(record_missing_flag));

endmodule // ssdf_formatter

// *** tb/ssdf_host_model.sv ***
// Host and DMA stand-in: streams the four-byte header image, drains read data.
// Assumes in_ready is a one-cycle grant sampled on the rising clock edge.
`timescale 1ns/1ps
module ssdf_host_model (
	input  wire logic       clk,
	input  wire logic       in_ready,
	output logic            in_valid,
	output logic [7:0]      in_data,
	input  wire logic       out_valid,
	output logic            out_ready
);
	// DMA always has a byte waiting, so no underrun zeros hide a framing slip
	logic [7:0] img [4] = '{8'hfe, 8'h05, 8'h10, 8'h03};
	logic [1:0] k = 2'h0;
	assign in_valid = 1'b1;
	assign in_data = img[k];
	assign out_ready = 1'b1;
	always @(posedge clk) begin
		k <= k + {1'b0, in_ready};
	end
endmodule // ssdf_host_model

// *** tb/ssdf_formatter_tb.sv ***
// Self-checking bench for the sector framer.
// Assumes one byte tick per two clocks and the host model on the DMA side.
`timescale 1ns/1ps
module ssdf_formatter_tb;
	logic clk = 0, sys_rst = 1, cmd_valid = 0, drive_ready = 0, power_fail = 0;
	logic index_pulse = 0, byte_tick = 0, gate_seen = 0;
	logic [1:0] cmd_op = 0, sel_req = 0, drive_sel;
	logic [3:0] head = 4'h1;
	logic [7:0] sect = 8'h03;
	logic [10:0] cyl = 11'h005;
	logic rd_valid = 0, rd_mark = 0;
	logic [7:0] rd_byte = 0;
	logic [15:0] hc, dc, wc;
	logic cmd_ready, wr_mark, wr_gate, in_valid, in_ready, out_valid, out_ready, busy, op_done;
	logic rmf, crc_e, bad_s, ovr;
	logic [7:0] wr_data, in_data, out_data;
	logic [8:0] e;
	int err_count = 0, n_compared = 0, dones = 0, d0, i, nrd = 0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		dones <= dones + int'(op_done === 1'b1);
		gate_seen <= gate_seen | (wr_gate === 1'b1);
	end
	// Read data is sampled mid-cycle, away from the edge that pops it
	always @(negedge clk) begin
		if (out_valid === 1'b1) begin
			chk(out_data, 8'(nrd));
			nrd++;
		end
	end
	ssdf_formatter uut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .tgt_head(head), .tgt_sector(sect),
		.tgt_cyl(cyl), .sel_req(sel_req), .drive_ready(drive_ready),
		.power_fail(power_fail), .drive_sel(drive_sel), .index_pulse(index_pulse),
		.byte_tick(byte_tick), .wr_data(wr_data), .wr_mark(wr_mark), .wr_gate(wr_gate),
		.rd_valid(rd_valid), .rd_byte(rd_byte), .rd_mark(rd_mark), .in_valid(in_valid),
		.in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready), .busy(busy), .op_done(op_done),
		.record_missing_flag(rmf), .crc_error(crc_e), .bad_sector(bad_s), .overrun(ovr));
	ssdf_host_model host (.clk(clk), .in_ready(in_ready), .in_valid(in_valid),
		.in_data(in_data), .out_valid(out_valid), .out_ready(out_ready));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task tick;
		@(negedge clk) byte_tick = 1;
		@(negedge clk) byte_tick = 0;
	endtask
	task idx;
		@(negedge clk) index_pulse = 1;
		repeat (2) tick;
		index_pulse = 0;
	endtask
	task cmd(input logic [1:0] op);
		d0 = dones;
		@(negedge clk) begin cmd_op = op; cmd_valid = 1; end
		@(negedge clk) cmd_valid = 0;
	endtask
	// Ticks keep running so a stuck wait cannot hide behind a frozen channel
	task wait_done;
		int k;
		k = 0;
		while (dones == d0 && k < 400) begin tick; k++; end
		if (k == 400) begin err_count++; $display("MISMATCH %0t timeout", $time); complete_run; end
		chk(8'(dones), 8'(d0 + 1));
	endtask
	function logic [8:0] fexp(int n);
		int s;
		s = (n - 30) % 563;
		if (n < 16 || n >= 9601) return 9'h04e;
		if (n < 30) return 9'h000;
		if (s == 0 || s == 29) return 9'h0a1;
		if (s == 1) return 9'h0fe;
		if (s == 2) return 9'h005;
		if (s == 3) return 9'h010;
		if (s == 4) return 9'h003;
		if (s == 5 || s == 543) return {1'b0, (s == 5) ? hc[15:8] : dc[15:8]};
		if (s == 6 || s == 544) return {1'b0, (s == 6) ? hc[7:0] : dc[7:0]};
		if (s == 30) return 9'h0f8;
		if (s inside {[7:28], [545:547]}) return 9'h000;
		if (s inside {[31:542], [548:562]}) return 9'h04e;
		return 9'h100;
	endfunction
	// Bit-serial checksum, kept apart from the byte-wide form in the design
	function logic [15:0] crcb(input logic [15:0] c, input logic [7:0] b);
		for (int j = 7; j >= 0; j--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction
	// Host image bytes in the order the host model hands them out
	function logic [7:0] himg(int n);
		return 8'(32'hfe051003 >> (24 - 8 * (n % 4)));
	endfunction
	task rd(input logic [7:0] b, input logic m);
		@(negedge clk) begin rd_valid = 1; rd_byte = b; rd_mark = m; end
		@(negedge clk) begin rd_valid = 0; rd_mark = 0; end
	endtask
	// Header for cylinder 5, head byte hb, sector sb; x spoils the checksum on purpose
	task hdr(input logic [7:0] hb, input logic [7:0] sb, input logic [15:0] x);
		logic [15:0] c;
		c = crcb(crcb(crcb(crcb(crcb(16'hffff, 8'ha1), 8'hfe), 8'h05), hb), sb) ^ x;
		rd(8'ha1, 1); rd(8'hfe, 0); rd(8'h05, 0); rd(hb, 0); rd(sb, 0);
		rd(c[15:8], 0); rd(c[7:0], 0);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_select;
		sel_req = 2'h1; repeat (3) @(negedge clk);
		chk(drive_sel, 2'h1);
		sel_req = 2'h2; power_fail = 1; repeat (3) @(negedge clk);
		chk(drive_sel, 0);
		chk(8'(dones), 8'h00);
		power_fail = 0; sel_req = 2'h1;
		$display("select done");
	endtask
	task t_wait_ready;
		cmd(2'h3); repeat (20) tick;
		chk(8'(dones), 8'(d0));
		drive_ready = 1; wait_done;
		$display("wait ready done");
	endtask
	task t_write_missing;
		cmd(2'h1); repeat (5) tick; idx; repeat (5) tick; idx; wait_done;
		chk(rmf, 1);
		chk(gate_seen, 0);
		$display("write missing done");
	endtask
	task t_reset;
		cmd(2'h3); repeat (2) @(negedge clk);
		chk(busy, 1);
		sys_rst = 1; repeat (2) @(negedge clk);
		sys_rst = 0; repeat (3) @(negedge clk);
		chk(busy, 0);
		chk(8'(dones), 8'(d0));
		$display("reset done");
	endtask
	task t_write_bad;
		cmd(2'h1); hdr(8'h18, 8'h03, 16'h0000); wait_done;
		chk(bad_s, 1);
		cmd(2'h1); hdr(8'h10, 8'h03, 16'h0001); wait_done;
		chk(crc_e, 1);
		chk(bad_s, 0);
		chk(gate_seen, 0);
		$display("write bad done");
	endtask
	task t_read;
		cmd(2'h0); hdr(8'h10, 8'h04, 16'h0000); hdr(8'h10, 8'h03, 16'h0000);
		wc = crcb(crcb(16'hffff, 8'ha1), 8'hf8);
		rd(8'ha1, 1); rd(8'hf8, 0);
		for (i = 0; i < 512; i++) begin wc = crcb(wc, 8'(i)); rd(8'(i), 0); end
		rd(wc[15:8], 0); rd(wc[7:0], 0); wait_done;
		chk(8'(nrd >> 2), 8'h80);
		chk({5'h00, crc_e, rmf, ovr}, 8'h00);
		$display("read done");
	endtask
	task t_write_ok;
		cmd(2'h1); hdr(8'h10, 8'h04, 16'h0000); hdr(8'h10, 8'h03, 16'h0000);
		chk(gate_seen, 0);
		wc = crcb(crcb(16'hffff, 8'ha1), 8'hf8);
		for (i = 0; i < 512; i++) wc = crcb(wc, himg(i));
		for (i = 0; i < 546; i++) begin
			tick;
			if (i < 12 || (i > 527 && i < 531)) e = 9'h000;
			else if (i == 12) e = 9'h0a1;
			else if (i == 13) e = 9'h0f8;
			else if (i < 526) e = {1'b0, himg(i - 14)};
			else if (i == 526) e = {1'b0, wc[15:8]};
			else if (i == 527) e = {1'b0, wc[7:0]};
			else e = 9'h04e;
			chk(wr_data, e[7:0]);
			chk(wr_mark, i == 12);
			chk(wr_gate, 1);
		end
		wait_done;
		chk(crc_e, 0);
		$display("write ok done");
	endtask
	task t_format;
		hc = crcb(crcb(crcb(crcb(crcb(16'hffff, 8'ha1), 8'hfe), 8'h05), 8'h10), 8'h03);
		dc = crcb(crcb(16'hffff, 8'ha1), 8'hf8);
		for (i = 0; i < 512; i++) dc = crcb(dc, 8'h4e);
		cmd(2'h2);
		// Index without ticks, so the first checked byte is the first one written
		@(negedge clk) index_pulse = 1;
		@(negedge clk) index_pulse = 0;
		for (i = 0; i < 9700; i++) begin
			tick;
			e = fexp(i);
			if (!e[8]) chk(wr_data, e[7:0]);
			chk(wr_mark, i >= 30 && i < 9601 && ((i - 30) % 563 == 0 || (i - 30) % 563 == 29));
		end
		chk(8'(dones), 8'(d0));
		idx; wait_done;
		$display("format done");
	endtask
	initial begin
		repeat (4) @(negedge clk);
		chk(cmd_ready, 1);
		sys_rst = 0;
		chk(8'(dones), 8'h00);
		t_select;
		t_reset;
		t_wait_ready;
		t_write_missing;
		t_write_bad;
		t_read;
		t_write_ok;
		t_format;
		complete_run;
	end
endmodule // ssdf_formatter_tb
